// ===== core/sef_pkg.sv
/*
 sef_pkg: constants of the serial memory front end (opcodes, status layout,
 protect ranges, self-timed write time, reset values).
 Assumes a single 50 MHz core clock; all users reference names as sef_pkg::name.
*/
package sef_pkg;
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEMORY_READ = 8'h03;
  localparam logic [7:0] OP_MEMORY_WRITE = 8'h02;

  // status byte bit positions
  localparam int unsigned ST_LOCK_POS = 7;
  localparam int unsigned ST_RANGE_HI_POS = 3;
  localparam int unsigned ST_RANGE_LO_POS = 2;
  localparam int unsigned ST_LATCH_POS = 1;
  localparam int unsigned ST_BUSY_POS = 0;

  // protect range lower bounds
  localparam logic [14:0] PROT_QUARTER_BASE = 15'h6000;
  localparam logic [14:0] PROT_HALF_BASE = 15'h4000;

  // delivery values of the nonvolatile bits
  localparam logic STATUS_LOCK_RST = 1'b0;
  localparam logic [1:0] PROTECT_RANGE_RST = 2'h0;

  // self-timed write cycle
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned WRITE_TIME_NS = 5000000;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;

  // byte counts that end an instruction or its address phase
  localparam logic [6:0] LEN_OPCODE_ONLY = 7'h01;
  localparam logic [6:0] LEN_STATUS_WRITE = 7'h02;
  localparam logic [6:0] LEN_ADDR_DONE = 7'h03;
  localparam logic [6:0] LEN_WRITE_MIN = 7'h04;

  typedef enum logic [2:0] {
    SEF_OPCODE = 3'b000,
    SEF_ADDR = 3'b001,
    SEF_DATA = 3'b011,
    SEF_OUT = 3'b010,
    SEF_DROP = 3'b110
  } sef_state_type;
endpackage : sef_pkg

// ===== core/sef_sync.sv
/*
 sef_sync: two flip-flop synchroniser for a group of pin levels.
 Assumes the inputs are asynchronous levels; only the second stage is read.
*/
`timescale 1ns/1ns
module sef_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds the second stage only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : sef_sync

// ===== core/sef_cycle_timer.sv
/*
 sef_cycle_timer: self-timed programming cycle, busy for CYCLES clocks.
 Assumes start_i is a one-cycle pulse that is ignored while busy.
*/
`timescale 1ns/1ns
module sef_cycle_timer #(
  parameter int unsigned CYCLES = sef_pkg::WRITE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] left_r;

  initial begin
    if (CYCLES < 2) $error("sef_cycle_timer: CYCLES must be at least 2");
  end

  // count down; done pulses in the cycle busy drops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_r <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i && !busy_o) begin
      left_r <= CW'(CYCLES - 1);
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else if (busy_o && left_r == '0) begin
      busy_o <= 1'b0;
      done_o <= 1'b1;
    end else begin
      left_r <= busy_o ? left_r - 1'b1 : left_r;
      done_o <= 1'b0;
    end
  end
endmodule : sef_cycle_timer

// ===== core/sef_front_end.sv
/*
 sef_front_end: serial memory device front end with 32K x 8 array, page
 buffer, status bits and self-timed write cycle.
 Assumes the pins arrive asynchronously and the serial clock is well below
 a quarter of ref_clk_i; all pin levels pass two flip-flops first.
*/
`timescale 1ns/1ns
module sef_front_end #(
  parameter int unsigned WRITE_CYCLES = sef_pkg::WRITE_CYCLES,
  parameter int unsigned ADDR_W = 15,
  parameter int unsigned PAGE_BYTES = 64
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic standby_o,
  output logic selected_o,
  output logic paused_o,
  output logic write_in_progress_flag_o,
  output logic write_enable_latch_o
);
  localparam int unsigned PW = $clog2(PAGE_BYTES);

  initial begin
    if (ADDR_W != 15) $error("sef_front_end: protect ranges assume ADDR_W of 15");
    if (PAGE_BYTES < 2 || (1 << PW) != PAGE_BYTES) $error("sef_front_end: bad PAGE_BYTES");
    if (WRITE_CYCLES < PAGE_BYTES + 2) $error("sef_front_end: WRITE_CYCLES too short");
  end

  // address falls in the range selected by the protect bits
  function automatic logic is_protected(input logic [1:0] range, input logic [ADDR_W-1:0] a);
    case (range)
      2'h0: is_protected = 1'b0;
      2'h1: is_protected = (a >= sef_pkg::PROT_QUARTER_BASE);
      2'h2: is_protected = (a >= sef_pkg::PROT_HALF_BASE);
      default: is_protected = 1'b1;
    endcase
  endfunction : is_protected

  logic rst_meta_r, rst_n_r;
  logic sclk_s, cs_n_s, mosi_s, hold_n_s, wp_n_s;
  logic sclk_d_r, cs_d_r, armed_r, selected_r, hold_r;
  logic rise_ok, fall_ok, cs_end;
  sef_pkg::sef_state_type state_r;
  logic [7:0] opcode_r, rx_r, tx_r, rx_nxt, status_new_r;
  logic [2:0] bit_r;
  logic [6:0] nbytes_r;
  logic [ADDR_W-1:0] addr_r, addr_full;
  logic [ADDR_W-1:PW] page_base_r;
  logic [PW:0] walk_r;
  logic [7:0] mem [0:(1 << ADDR_W)-1];
  logic [7:0] page_buf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] page_valid_r;
  logic latch_r, start_write, start_status, commit_mem_r, busy, done;
  logic status_lock_bit_r = sef_pkg::STATUS_LOCK_RST;
  logic [1:0] protect_range_r = sef_pkg::PROTECT_RANGE_RST;
  logic [7:0] status_byte;

  // reset release through two flops; nothing runs before it lifts
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  sef_sync #(
    .WIDTH(5),
    .RST_VAL(5'h0a)  // select reads low until the pin is seen high: no false edge
  ) u_pin_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .d_i({cs_n_i, hold_n_i, sclk_i, wp_n_i, mosi_i}),
    .q_o({cs_n_s, hold_n_s, sclk_s, wp_n_s, mosi_s})
  );

  sef_cycle_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .start_i(start_write || start_status),
    .busy_o(busy),
    .done_o(done)
  );

  // select qualification: a falling select edge is needed after reset
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      armed_r <= 1'b0;
      selected_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_n_s;
      if (cs_n_s) begin
        armed_r <= 1'b1;  // a low select at power-up never starts anything
      end
      if (cs_n_s) begin
        selected_r <= 1'b0;
      end else if (armed_r && cs_d_r) begin
        selected_r <= 1'b1;
      end
      // pause level follows the pause pin only while the serial clock is low
      if (cs_n_s || !selected_r) begin
        hold_r <= 1'b0;  // deselect while paused resets the interface
      end else if (!sclk_s) begin
        hold_r <= !hold_n_s;
      end
    end
  end

  assign rise_ok = selected_r && !cs_n_s && !hold_r && sclk_s && !sclk_d_r;
  assign fall_ok = selected_r && !cs_n_s && !hold_r && !sclk_s && sclk_d_r;
  assign cs_end = selected_r && cs_n_s;
  assign rx_nxt = {rx_r[6:0], mosi_s};
  assign addr_full = {addr_r[ADDR_W-9:0], rx_nxt};
  assign status_byte = {status_lock_bit_r, 3'h0, protect_range_r, latch_r, busy};

  // a write instruction executes only when select rises on a byte boundary
  always_comb begin
    start_write = 1'b0;
    start_status = 1'b0;
    if (cs_end && !hold_r && bit_r == 3'h0 && !busy && latch_r) begin
      if (opcode_r == sef_pkg::OP_MEMORY_WRITE && nbytes_r >= sef_pkg::LEN_WRITE_MIN) begin
        start_write = 1'b1;
      end
      if (opcode_r == sef_pkg::OP_STATUS_WRITE && nbytes_r == sef_pkg::LEN_STATUS_WRITE
          && !(status_lock_bit_r && !wp_n_s)) begin
        start_status = 1'b1;
      end
    end
  end

  // shift engine: opcode decode, address, data and output bytes
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= sef_pkg::SEF_OPCODE;
      opcode_r <= 8'h00;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      bit_r <= 3'h0;
      nbytes_r <= 7'h00;
      addr_r <= '0;
      status_new_r <= 8'h00;
    end else if (!selected_r || cs_n_s) begin
      state_r <= sef_pkg::SEF_OPCODE;  // abandoned on deselect
      bit_r <= 3'h0;
      if (!selected_r) begin
        nbytes_r <= 7'h00;
      end
    end else if (rise_ok && state_r != sef_pkg::SEF_DROP) begin
      rx_r <= rx_nxt;
      bit_r <= bit_r + 3'h1;
      if (bit_r == 3'h7) begin
        nbytes_r <= (nbytes_r == 7'h7f) ? nbytes_r : nbytes_r + 7'h01;
        case (state_r)
          sef_pkg::SEF_OPCODE: begin
            opcode_r <= rx_nxt;
            case (rx_nxt)
              sef_pkg::OP_SET_WRITE_LATCH,
              sef_pkg::OP_CLEAR_WRITE_LATCH,
              sef_pkg::OP_STATUS_WRITE: state_r <= sef_pkg::SEF_DATA;
              sef_pkg::OP_STATUS_READ: begin
                state_r <= sef_pkg::SEF_OUT;
                tx_r <= status_byte;
              end
              sef_pkg::OP_MEMORY_READ,
              sef_pkg::OP_MEMORY_WRITE: state_r <= sef_pkg::SEF_ADDR;
              default: state_r <= sef_pkg::SEF_DROP;
            endcase
          end
          sef_pkg::SEF_ADDR: begin
            addr_r <= addr_full;
            if (nbytes_r == sef_pkg::LEN_ADDR_DONE - 7'h01) begin
              if (opcode_r == sef_pkg::OP_MEMORY_READ) begin
                state_r <= sef_pkg::SEF_OUT;
                tx_r <= mem[addr_full];
                addr_r <= addr_full + 1'b1;
              end else begin
                state_r <= sef_pkg::SEF_DATA;
              end
            end
          end
          sef_pkg::SEF_DATA: begin
            if (opcode_r == sef_pkg::OP_STATUS_WRITE && nbytes_r == sef_pkg::LEN_OPCODE_ONLY) begin
              status_new_r <= rx_nxt;
            end
            if (opcode_r == sef_pkg::OP_MEMORY_WRITE) begin
              addr_r[PW-1:0] <= addr_r[PW-1:0] + 1'b1;  // rolls over inside the page
            end
          end
          sef_pkg::SEF_OUT: begin
            if (opcode_r == sef_pkg::OP_STATUS_READ) begin
              tx_r <= status_byte;  // status may be read again and again
            end else begin
              tx_r <= mem[addr_r];
              addr_r <= addr_r + 1'b1;  // wraps at the top of the array
            end
          end
          default: state_r <= sef_pkg::SEF_DROP;
        endcase
      end
    end else if (fall_ok && state_r == sef_pkg::SEF_OUT) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // page buffer fill; protected bytes are never marked for programming
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      page_valid_r <= '0;
      page_base_r <= '0;
    end else if (!busy && !selected_r) begin
      page_valid_r <= '0;
    end else if (!busy && rise_ok && bit_r == 3'h7 && state_r == sef_pkg::SEF_DATA
                 && opcode_r == sef_pkg::OP_MEMORY_WRITE) begin
      page_base_r <= addr_r[ADDR_W-1:PW];
      page_valid_r[addr_r[PW-1:0]] <= !is_protected(protect_range_r, addr_r);
    end
  end

  // buffer data has no reset; only valid bytes are ever copied
  always_ff @(posedge ref_clk_i) begin
    if (!busy && rise_ok && bit_r == 3'h7 && state_r == sef_pkg::SEF_DATA) begin
      page_buf[addr_r[PW-1:0]] <= rx_nxt;
    end
  end

  // during the self-timed cycle walk the page and program valid bytes
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      walk_r <= '0;
      commit_mem_r <= 1'b0;
    end else if (start_write) begin
      walk_r <= '0;
      commit_mem_r <= 1'b1;
    end else if (commit_mem_r && walk_r != (PW+1)'(PAGE_BYTES)) begin
      walk_r <= walk_r + 1'b1;
    end else if (done) begin
      commit_mem_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (commit_mem_r && walk_r != (PW+1)'(PAGE_BYTES) && page_valid_r[walk_r[PW-1:0]]) begin
      mem[{page_base_r, walk_r[PW-1:0]}] <= page_buf[walk_r[PW-1:0]];
    end
  end

  // write enable latch: cleared at reset and by the commands that consume it
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      latch_r <= 1'b0;
    end else if (cs_end && !hold_r && bit_r == 3'h0 && nbytes_r == sef_pkg::LEN_OPCODE_ONLY) begin
      if (opcode_r == sef_pkg::OP_SET_WRITE_LATCH) begin
        latch_r <= 1'b1;  // a set in the cycle a write ends wins
      end else if (opcode_r == sef_pkg::OP_CLEAR_WRITE_LATCH || done) begin
        latch_r <= 1'b0;
      end
    end else if (done) begin
      latch_r <= 1'b0;
    end
  end

  // nonvolatile bits: untouched by reset, updated only at cycle end
  always_ff @(posedge ref_clk_i) begin
    if (done && !commit_mem_r) begin
      status_lock_bit_r <= status_new_r[sef_pkg::ST_LOCK_POS];
      protect_range_r <= {status_new_r[sef_pkg::ST_RANGE_HI_POS],
                          status_new_r[sef_pkg::ST_RANGE_LO_POS]};
    end
  end

  // registered pin and status outputs
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
      standby_o <= 1'b1;
      selected_o <= 1'b0;
      paused_o <= 1'b0;
      write_in_progress_flag_o <= 1'b0;
      write_enable_latch_o <= 1'b0;
    end else begin
      if (fall_ok && state_r == sef_pkg::SEF_OUT) begin
        miso_o <= tx_r[7];
      end
      miso_oe_o <= selected_r && !cs_n_s && !hold_r && state_r == sef_pkg::SEF_OUT;
      standby_o <= !selected_r && !busy;
      selected_o <= selected_r && state_r != sef_pkg::SEF_DROP;
      paused_o <= hold_r;
      write_in_progress_flag_o <= busy;
      write_enable_latch_o <= latch_r;
    end
  end
endmodule : sef_front_end

// ===== sim/sef_front_end_assertions.sv
/*
 sef_front_end_assertions: pin-level timing checks of the serial memory front end.
 Assumes one core clock domain and pins driven just after its rising edge.
*/
`timescale 1ns/1ns
module sef_front_end_assertions #(
  parameter int unsigned WRITE_CYCLES = sef_pkg::WRITE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic standby_o,
  input wire logic selected_o,
  input wire logic paused_o,
  input wire logic write_in_progress_flag_o,
  input wire logic write_enable_latch_o
);
  logic sclk_d_r;
  logic [2:0] since_fall_r;
  logic [2:0] both_low_r;
  logic [3:0] cs_high_r;
  logic cs_seen_high_r;
  int unsigned busy_cnt_r;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // pin history counted raw, so a slip in the design's synchronisers still shows
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_d_r <= 1'b0;
      since_fall_r <= 3'h7;
      both_low_r <= 3'h0;
    end else begin
      sclk_d_r <= sclk_i;
      if (sclk_d_r && !sclk_i) begin
        since_fall_r <= 3'h0;
      end else if (since_fall_r != 3'h7) begin
        since_fall_r <= since_fall_r + 3'h1;
      end
      if (hold_n_i || sclk_i) begin
        both_low_r <= 3'h0;
      end else if (both_low_r != 3'h7) begin
        both_low_r <= both_low_r + 3'h1;
      end
    end
  end

  // select history and length of the busy window
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_high_r <= 4'h0;
      cs_seen_high_r <= 1'b0;
      busy_cnt_r <= 0;
    end else begin
      cs_high_r <= !cs_n_i ? 4'h0 : (cs_high_r == 4'hf ? cs_high_r : cs_high_r + 4'h1);
      cs_seen_high_r <= cs_seen_high_r | cs_n_i;
      busy_cnt_r <= write_in_progress_flag_o ? busy_cnt_r + 1 : 0;
    end
  end

  chk_float_deselected: assert property (cs_n_i [*6] |-> !miso_oe_o)
    else $error("serial output driven while deselected");
  chk_standby_when_idle: assert property (
    cs_n_i [*6] ##0 !write_in_progress_flag_o |-> ##[0:2] standby_o)
    else $error("no standby while deselected and idle");
  chk_busy_not_standby: assert property (write_in_progress_flag_o [*2] |-> !standby_o)
    else $error("standby during a write cycle");
  chk_first_select_edge: assert property (!cs_seen_high_r |-> !selected_o)
    else $error("selected without a falling select edge");
  chk_pause_low_clock: assert property ($rose(paused_o) |-> both_low_r >= 3'h2)
    else $error("pause entered without pause pin and clock low");
  chk_pause_floats: assert property (paused_o [*4] |-> !miso_oe_o)
    else $error("serial output driven while paused");
  chk_deselect_aborts: assert property (cs_n_i [*6] |-> !paused_o && !selected_o)
    else $error("pause or selection kept after deselect");
  chk_latch_at_deselect: assert property (
    $rose(write_enable_latch_o) |-> cs_high_r inside {[4'h2:4'h8]})
    else $error("write latch set away from the deselect");
  chk_write_needs_latch: assert property (
    $rose(write_in_progress_flag_o) |-> $past(write_enable_latch_o))
    else $error("write cycle started without the write latch");
  chk_busy_length: assert property (
    $fell(write_in_progress_flag_o) |-> busy_cnt_r == WRITE_CYCLES)
    else $error("write cycle length wrong");
  chk_latch_cleared_end: assert property (
    $fell(write_in_progress_flag_o) |-> ##[0:2] !write_enable_latch_o)
    else $error("write latch kept after write cycle");
  chk_output_after_fall: assert property (
    $changed(miso_o) && $past(miso_oe_o) && miso_oe_o |-> since_fall_r inside {[3'h1:3'h5]})
    else $error("serial output changed away from a clock fall");

  cover property ($rose(paused_o));
  cover property ($fell(write_in_progress_flag_o));
  cover property ($rose(write_enable_latch_o));
endmodule : sef_front_end_assertions

bind sef_front_end sef_front_end_assertions #(.WRITE_CYCLES(WRITE_CYCLES))
  i_sef_front_end_assertions (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk_i),
  .cs_n_i(cs_n_i), .hold_n_i(hold_n_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
  .standby_o(standby_o), .selected_o(selected_o), .paused_o(paused_o),
  .write_in_progress_flag_o(write_in_progress_flag_o),
  .write_enable_latch_o(write_enable_latch_o));

// ===== sim/sef_spi_master.sv
/*
 sef_spi_master: behavioural serial bus master driving the memory pins.
 Assumes its clock is the core clock; half a serial period is four core clocks.
*/
`timescale 1ns/1ns
module sef_spi_master (
  input wire logic clk_i,
  input wire logic miso_i,
  input wire logic miso_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  output logic hold_n_o
);
  // select starts low, as a line that is low at power-up
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    mosi_o = 1'b0;
    hold_n_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // one framed transfer of nb bits; optional pause before bit pz, abort while paused
  task automatic frame(input int nb, input logic [31:0] tx, input int pz, input bit ab,
                       output logic [31:0] rx);
    rx = '0;
    cs_n_o <= 1'b1;
    tick(4);
    cs_n_o <= 1'b0;
    tick(4);
    for (int i = nb - 1; i >= 0; i--) begin
      if (nb - 1 - i == pz) begin
        hold_n_o <= 1'b0; // pause only while selected
        mosi_o <= ~tx[i];
        tick(6);
        sclk_o <= 1'b1; // this pulse must be ignored
        tick(4);
        sclk_o <= 1'b0;
        tick(4);
        if (ab) begin
          cs_n_o <= 1'b1;
          tick(6);
        end
        hold_n_o <= 1'b1;
        tick(6);
      end
      mosi_o <= tx[i];
      tick(4);
      sclk_o <= 1'b1;
      tick(2);
      rx = {rx[30:0], miso_oe_i ? miso_i : 1'bx}; // floating line reads unknown
      tick(2);
      sclk_o <= 1'b0;
    end
    tick(4);
    cs_n_o <= 1'b1; // after the last rising edge, before any other
    mosi_o <= ~mosi_o; // a released line does not keep its last level
    tick(8);
  endtask : frame
endmodule : sef_spi_master

// ===== sim/test_sef_front_end.sv
/*
 test_sef_front_end: self-checking bench of the serial memory front end.
 Assumes the master model owns the serial pins and the bench owns write-protect.
*/
`timescale 1ns/1ns
module test_sef_front_end;
  localparam logic [14:0] ADR [3] = '{15'h1000, 15'h5000, 15'h7fff};
  logic ref_clk_i = 1'b0;
  logic arst_n_i;
  logic wp_n_i;
  logic sclk, cs_n, mosi, hold_n, miso, miso_oe;
  logic standby, selected, paused, busy, write_enable_latch;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 32'h79b6;
  int cycles = 0;
  logic [31:0] rx;
  logic [7:0] d;
  logic [7:0] mem [3];

  always #10 ref_clk_i = ~ref_clk_i;

  sef_front_end #(.WRITE_CYCLES(100)) i_sef_front_end (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .hold_n_i(hold_n),
    .wp_n_i(wp_n_i), .miso_o(miso), .miso_oe_o(miso_oe), .standby_o(standby),
    .selected_o(selected), .paused_o(paused), .write_in_progress_flag_o(busy),
    .write_enable_latch_o(write_enable_latch));

  sef_spi_master i_sef_spi_master (.clk_i(ref_clk_i), .miso_i(miso), .miso_oe_i(miso_oe),
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .hold_n_o(hold_n));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // whole run needs about 13000 cycles; a hang is cut off well above that
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // protected ranges worked out from the two range bits
  function automatic logic prot(input logic [1:0] bp, input logic [14:0] a);
    case (bp)
      2'h0: return 1'b0;
      2'h1: return a >= 15'h6000;
      2'h2: return a >= 15'h4000;
      default: return 1'b1;
    endcase
  endfunction : prot

  task automatic op(input int nb, input logic [31:0] tx);
    i_sef_spi_master.frame(nb, tx, -1, 1'b0, rx);
  endtask : op

  task automatic status(input logic [7:0] exp);
    op(16, {16'h0, sef_pkg::OP_STATUS_READ, 8'h00});
    check("status byte", rx[7:0], exp);
  endtask : status

  task automatic wait_idle;
    for (int i = 0; i < 400 && busy === 1'b1; i++) @(posedge ref_clk_i);
    check("busy flag", busy, 1'b0);
  endtask : wait_idle

  task automatic set_status(input logic [7:0] v);
    op(8, {24'h0, sef_pkg::OP_SET_WRITE_LATCH});
    op(16, {16'h0, sef_pkg::OP_STATUS_WRITE, v});
    wait_idle();
  endtask : set_status

  initial begin
    arst_n_i = 1'b0;
    wp_n_i = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    check("selected", selected, 1'b0);
    check("latch", write_enable_latch, 1'b0);
    check("standby", standby, 1'b1);
    status(8'h00);
    op(16, {16'h0, sef_pkg::OP_STATUS_WRITE, 8'h8c});
    check("busy no latch", busy, 1'b0);
    op(8, {24'h0, sef_pkg::OP_SET_WRITE_LATCH});
    check("latch set", write_enable_latch, 1'b1);
    op(8, {24'h0, sef_pkg::OP_CLEAR_WRITE_LATCH});
    check("latch clear", write_enable_latch, 1'b0);
    op(9, {23'h0, sef_pkg::OP_SET_WRITE_LATCH, 1'b0});
    check("latch late deselect", write_enable_latch, 1'b0);
    op(16, {16'h0, 8'ha5, sef_pkg::OP_SET_WRITE_LATCH});
    check("latch after bad opcode", write_enable_latch, 1'b0);
    i_sef_spi_master.frame(8, {24'h0, sef_pkg::OP_SET_WRITE_LATCH}, 4, 1'b1, rx);
    check("latch after abort", write_enable_latch, 1'b0);
    check("paused after abort", paused, 1'b0);
    op(8, {24'h0, sef_pkg::OP_SET_WRITE_LATCH});
    op(15, {17'h0, sef_pkg::OP_STATUS_WRITE, 7'h46});
    check("busy odd count", busy, 1'b0);
    i_sef_spi_master.frame(16, {16'h0, sef_pkg::OP_STATUS_READ, 8'h00}, 11, 1'b0, rx);
    check("paused status", rx[7:0], 8'h02);
    op(16, {16'h0, sef_pkg::OP_STATUS_WRITE, 8'hff});
    check("busy status write", busy, 1'b1);
    check("standby while busy", standby, 1'b0);
    status(8'h03);
    wait_idle();
    status(8'h8c);
    wp_n_i <= 1'b0; // only between instructions
    set_status(8'h00);
    status(8'h8e);
    wp_n_i <= 1'b1;
    set_status(8'h00);
    for (int k = 0; k < 4; k++) begin
      set_status({4'h0, k[1:0], 2'h0});
      for (int j = 0; j < 3; j++) begin
        d = 8'($random(seed));
        op(8, {24'h0, sef_pkg::OP_SET_WRITE_LATCH});
        op(32, {sef_pkg::OP_MEMORY_WRITE, 1'b0, ADR[j], d});
        wait_idle();
        if (!prot(k[1:0], ADR[j])) mem[j] = d;
        op(32, {sef_pkg::OP_MEMORY_READ, 1'b0, ADR[j], 8'h00});
        check("memory byte", rx[7:0], mem[j]);
      end
    end
    wait_idle(); // no programming cycle may still run when power goes
    tally_and_finish();
  end
endmodule : test_sef_front_end
